// *** tb/apt_top_tb.sv ***
// Purpose: self-checking bench for the periodic wake-up timer and trim block
// Assumes: zero-wait apb slave, 8-bit registers in the low byte lane
// Notes:   register model is an int array; timer periods are measured in pclk cycles
module apt_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import apt_pkg::*;

  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, special_mode;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0]  pstrb;
  logic [5:0]  flash_lp_trim, lp_bits;
  logic [7:0]  flash_temp_trim, test_bits;
  logic [3:0]  temp_code;
  logic        flag, irq;
  logic [15:0] lf;
  int          n_errors, n_compared, cyc, m [0:63];
  bit          spec;

  apt_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .special_mode(special_mode), .flash_lp_trim(flash_lp_trim),
    .flash_temp_trim(flash_temp_trim), .lowpower_clock_trim_bits(lp_bits),
    .temp_offset_code(temp_code), .factory_test_bits(test_bits),
    .periodic_timeout_flag(flag), .periodic_irq(irq));

  always #50 pclk = ~pclk;
  always @(posedge pclk) cyc <= cyc + 1;

  function automatic logic [15:0] lfsr_next(logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic done(string name);
    $display("test %s done", name);
  endtask

  task automatic apb(logic w, logic [5:0] idx, logic [7:0] d, output logic [31:0] rd, output logic err);
    int k;
    k = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    paddr   <= {idx, 2'b00};
    pwrite  <= w;
    pwdata  <= {24'h00_0000, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && k < 16) begin
      @(posedge pclk);
      k++;
    end
    if (k >= 16) chk("pready", {31'h0, pready}, 32'h0000_0001);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // model update follows the access rules of each register
  task automatic wr(logic [5:0] idx, logic [7:0] d);
    logic [31:0] v;
    logic        e;
    int          nv;
    apb(1'b1, idx, d, v, e);
    chk("wr_slverr", {31'h0, e}, 32'h0000_0000);
    case (idx)
      IDX_CTRL: begin
        nv = (m[18] & 'h80) | (d & 'h06);
        if (!m[18][2] && !d[2]) nv = (nv & 'h06) | (d & 'h80);
        m[18] = nv;
      end
      IDX_LP_TRIM:                m[19] = d & 'h3F;
      IDX_RATE_HIGH, IDX_RATE_LOW: if (!m[18][2]) m[idx] = d;
      IDX_TEST:                   if (spec) m[22] = d;
      IDX_TEMP_TRIM:              m[23] = d & 'h8F;
      default: ;
    endcase
  endtask

  task automatic rd(logic [5:0] idx);
    logic [31:0] v, x;
    logic        e;
    apb(1'b0, idx, 8'h00, v, e);
    x = m[idx];
    if (idx == IDX_CTRL) begin
      v = v & 32'h0000_0086;
      x = x & 32'h0000_0086;
    end
    chk("rdata", v, x);
    chk("rd_slverr", {31'h0, e}, 32'h0000_0000);
  endtask

  task automatic chk_outs();
    logic [7:0] t;
    t = m[23];
    chk("lp_bits", {26'h0, lp_bits}, m[19]);
    chk("test_bits", {24'h0, test_bits}, m[22]);
    chk("temp_code", {28'h0, temp_code}, {28'h0, t[7] ? t[3:0] : 4'h0});
  endtask

  task automatic wait_flag(output int t);
    int k;
    k = 0;
    @(negedge pclk);
    while (flag !== 1'b1 && k < 6000) begin
      @(negedge pclk);
      k++;
    end
    if (k >= 6000) chk("flag_wait", {31'h0, flag}, 32'h0000_0001);
    t = cyc;
  endtask

  initial begin
    repeat (60000) @(posedge pclk);
    n_errors++;
    report_and_stop();
  end

  initial begin
    static logic [5:0] idxs [5] = '{IDX_LP_TRIM, IDX_RATE_HIGH, IDX_RATE_LOW, IDX_TEST, IDX_TEMP_TRIM};
    static logic [5:0] trims [3] = '{6'h00, 6'h21, 6'h10};
    logic [7:0]  d;
    logic [31:0] v;
    logic        e;
    int          t0, t1, t2, t3, ts, tk, tr;
    pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 8'h00;
    pwdata = 32'h0000_0000; pstrb = 4'hF; special_mode = 0; spec = 0;
    n_errors = 0; n_compared = 0; lf = 16'h0017;
    lf = lfsr_next(lf);
    flash_lp_trim = lf[5:0];
    lf = lfsr_next(lf);
    flash_temp_trim = lf[7:0];
    foreach (m[i]) m[i] = 0;
    m[19] = flash_lp_trim;
    m[23] = flash_temp_trim & 8'h8F;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int j = 0; j < 5; j++) rd(idxs[j]);
    rd(IDX_CTRL);
    chk_outs();
    chk("flag_rst", {31'h0, flag}, 32'h0000_0000);
    done("reset");
    for (int i = 0; i < 6; i++) begin
      spec = i[0];
      special_mode <= spec;
      repeat (3) @(posedge pclk);
      for (int j = 0; j < 5; j++) begin
        lf = lfsr_next(lf);
        d = lf[7:0];
        d[7] = i[1];
        wr(idxs[j], d);
        rd(idxs[j]);
      end
      chk_outs();
    end
    done("registers");
    apb(1'b1, 6'h20, 8'hA5, v, e);
    chk("bad_wr_err", {31'h0, e}, 32'h0000_0001);
    apb(1'b0, 6'h20, 8'h00, v, e);
    chk("bad_rd_err", {31'h0, e}, 32'h0000_0001);
    chk("bad_rd_data", v, 32'h0000_0000);
    done("unmapped");
    wr(IDX_RATE_HIGH, 8'h00);
    wr(IDX_RATE_LOW, 8'h03);
    wr(IDX_CTRL, 8'h81);
    wr(IDX_CTRL, 8'h86);
    wait_flag(t0);
    @(negedge pclk);
    chk("irq", {31'h0, irq}, 32'h0000_0001);
    wr(IDX_CTRL, 8'h87);
    wait_flag(t1);
    wr(IDX_CTRL, 8'h87);
    wait_flag(t2);
    chk("bus_period", t2 - t1, 2 * (3 + 1));
    wr(IDX_RATE_LOW, 8'h55);
    wr(IDX_CTRL, 8'h06);
    wr(IDX_CTRL, 8'h87);
    wait_flag(t3);
    chk("locked_period", t3 - t2, 4 * (3 + 1));
    rd(IDX_RATE_LOW);
    rd(IDX_CTRL);
    done("bus_source");
    wr(IDX_CTRL, 8'h01);
    repeat (40) @(negedge pclk);
    chk("stopped", {31'h0, flag}, 32'h0000_0000);
    rd(IDX_CTRL);
    done("disable");
    wr(IDX_LP_TRIM, 8'h00);
    wr(IDX_RATE_LOW, 8'h00);
    wr(IDX_CTRL, 8'h01);
    rd(IDX_CTRL);
    wr(IDX_CTRL, 8'h84);
    ts = cyc;
    wait_flag(t0);
    // free-running tick phase adds up to one tick on top of the gate delay
    chk("first_lp", (t0 - ts >= 6 * LP_BASE_INT) && (t0 - ts <= 7 * LP_BASE_INT + 8), 1);
    foreach (trims[j]) begin
      wr(IDX_LP_TRIM, {2'b00, trims[j]});
      tr = trims[j][5] ? int'(trims[j]) - 64 : int'(trims[j]);
      tk = LP_BASE_INT - tr;
      wr(IDX_CTRL, 8'h05);
      wait_flag(t1);
      wr(IDX_CTRL, 8'h05);
      wait_flag(t2);
      wr(IDX_CTRL, 8'h05);
      wait_flag(t3);
      chk("lp_period", t3 - t2, 4 * tk);
    end
    done("lp_source");
    report_and_stop();
  end
endmodule // apt_top_tb

// *** verilog/apt_lp_tick.sv ***
// Purpose: trimmable low-power clock, produced as a tick enable on pclk
// Assumes: trim is a signed six-bit value, base period 500 pclk cycles
// Notes:   each trim lsb moves the period by one pclk cycle
module apt_lp_tick (
  // clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // trim
  input  wire logic [5:0] trim,
  // tick out
  output logic            lp_tick
);
  import apt_pkg::*;

  logic [9:0] period;
  logic [9:0] cnt_r;
  logic       tick_r;

  // msb adds 32 cycles, lower bits subtract 16,8,4,2,1 (see RQ3)
  assign period  = LP_BASE_CYCLES - {{4{trim[5]}}, trim};  // see RQ1
  assign lp_tick = tick_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r  <= 10'h000;
      tick_r <= 1'b0;
    end else if (cnt_r >= period - 10'h001) begin
      cnt_r  <= 10'h000;
      tick_r <= 1'b1;
    end else begin
      cnt_r  <= cnt_r + 10'h001;
      tick_r <= 1'b0;
    end
  end

  a_tick_single: assert property (@(posedge pclk) disable iff (!presetn)
    tick_r |=> !tick_r) else $error("low-power tick wider than one cycle");  // see RQ3

endmodule // apt_lp_tick

// *** verilog/apt_pkg.sv ***
// Purpose: shared constants for the periodic wake-up timer and trim block
// Assumes: pclk at 10 MHz, APB with 32-bit data, one word per register
// Notes:   register offsets are indices; byte address is four times the index
package apt_pkg;

  // clock and time figures
  localparam int unsigned PCLK_PERIOD_NS = 100;
  localparam int unsigned LP_PERIOD_NS   = 50000;  // 20 kHz low-power clock
  localparam int unsigned LP_BASE_INT    = (LP_PERIOD_NS + PCLK_PERIOD_NS - 1) / PCLK_PERIOD_NS;
  localparam logic [9:0]  LP_BASE_CYCLES = LP_BASE_INT[9:0];
  // three skipped ticks plus free tick phase give 2..3 ticks of first-period latency
  localparam logic [1:0]  GATE_TICKS     = 2'h3;

  // register indices
  localparam logic [5:0] IDX_CTRL      = 6'h12;
  localparam logic [5:0] IDX_LP_TRIM   = 6'h13;
  localparam logic [5:0] IDX_RATE_HIGH = 6'h14;
  localparam logic [5:0] IDX_RATE_LOW  = 6'h15;
  localparam logic [5:0] IDX_TEST      = 6'h16;
  localparam logic [5:0] IDX_TEMP_TRIM = 6'h17;

  // control register fields
  localparam int unsigned CTRL_CLK_SEL = 7;
  localparam int unsigned CTRL_FE      = 2;
  localparam int unsigned CTRL_IE      = 1;
  localparam int unsigned CTRL_FLAG    = 0;

  // temperature and low-power trim fields
  localparam int unsigned TEMP_OE_BIT  = 7;
  localparam logic [7:0]  TEMP_MASK    = 8'h8F;
  localparam logic [7:0]  LP_TRIM_MASK = 8'h3F;

  // values after reset
  localparam logic [5:0]  LP_TRIM_RST   = 6'h00;
  localparam logic [7:0]  TEMP_TRIM_RST = 8'h00;
  localparam logic [15:0] RATE_RST      = 16'h0000;
  localparam logic [7:0]  TEST_RST      = 8'h00;

endpackage : apt_pkg

// *** verilog/apt_rate_timer.sv ***
// Purpose: periodic time-out counter on bus clock or low-power ticks
// Assumes: rate and source stay fixed while enabled
// Notes:   timeout is a one-cycle pulse from a flip-flop
module apt_rate_timer (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // configuration
  input  wire logic        enable,
  input  wire logic        clk_sel,
  input  wire logic [15:0] rate,
  input  wire logic        lp_tick,
  // event
  output logic             timeout
);
  import apt_pkg::*;

  logic [18:0] rate_p1;
  logic [18:0] target;
  logic [18:0] cnt_r;
  logic [1:0]  gate_r;
  logic        counting;
  logic        tick;
  logic        timeout_r;

  assign rate_p1  = {3'h0, rate} + 19'h0_0001;
  // bus: 2*(R+1) cycles; low-power: 2*(R+1)*2 ticks (see RQ7, RQ8)
  assign target   = clk_sel ? {rate_p1[17:0], 1'b0} : {rate_p1[16:0], 2'h0};
  assign tick     = clk_sel | lp_tick;
  // gate release holds off the first three low-power ticks (see RQ9)
  assign counting = enable & (clk_sel | (gate_r == 2'h0));
  assign timeout  = timeout_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gate_r <= GATE_TICKS;
    end else if (!enable) begin
      gate_r <= GATE_TICKS;
    end else if (!clk_sel && lp_tick && gate_r != 2'h0) begin
      gate_r <= gate_r - 2'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r     <= 19'h0_0000;
      timeout_r <= 1'b0;
    end else if (!counting) begin
      cnt_r     <= enable ? cnt_r : 19'h0_0000;  // see RQ15
      timeout_r <= 1'b0;
    end else if (tick && cnt_r == target - 19'h0_0001) begin
      cnt_r     <= 19'h0_0000;  // restart with same rate (see RQ17)
      timeout_r <= 1'b1;
    end else begin
      cnt_r     <= tick ? cnt_r + 19'h0_0001 : cnt_r;
      timeout_r <= 1'b0;
    end
  end

  // helper: cycles since previous time-out in bus mode
  logic [18:0] since_r;
  logic        seen_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      since_r <= 19'h0_0000;
      seen_r  <= 1'b0;
    end else if (!enable) begin
      since_r <= 19'h0_0000;
      seen_r  <= 1'b0;
    end else if (timeout_r) begin
      since_r <= 19'h0_0000;
      seen_r  <= 1'b1;
    end else begin
      since_r <= since_r + 19'h0_0001;
    end
  end

  a_bus_period: assert property (@(posedge pclk) disable iff (!presetn)  // see RQ8
    (timeout_r && seen_r && clk_sel) |-> since_r == target - 19'h0_0001)
    else $error("bus-clock period differs from 2*(rate+1)");
  a_gate_hold: assert property (@(posedge pclk) disable iff (!presetn)  // see RQ9
    (enable && !clk_sel && gate_r != 2'h0) |=> !timeout_r)
    else $error("time-out during clock gate release");

endmodule // apt_rate_timer

// *** verilog/apt_top.sv ***
// Purpose: periodic wake-up timer with low-power clock, temperature and test trims
// Assumes: APB slave, zero wait states, 8-bit registers in the low byte lane
// Notes:   trims load from flash inputs at the first edge after reset release
//
// How it works
// RQ1: six-bit signed trim register adjusts the low-power clock period.
// RQ2: low-power trim loads from flash right after reset release.
// RQ3: trim msb lengthens period; lower bits shorten it with halving weights.
// RQ4: low-power and temperature trims are read and write at any time.
// RQ5: sixteen-bit rate value in high and low byte registers sets time-out.
// RQ6: rate writes only land while feature enable is clear; reads always allowed.
// RQ7: low-power source period is 2*(rate+1) times two low-power periods.
// RQ8: bus source period is 2*(rate+1) bus clock periods.
// RQ9: first low-power time-out after enable is two to three ticks late.
// RQ10: test register reads always; writes land only in special mode.
// RQ11: temperature trim loads from flash right after reset release.
// RQ12: offset enable clear disables temperature offset, offset bits ignored.
// RQ13: offset enable set lets four binary-weighted bits select the offset.
// RQ14: clock select chooses low-power at 0, bus at 1; locked while enabled.
// RQ15: setting feature enable starts the timer; clearing it stops it.
// RQ16: time-out sets a flag cleared by writing one; requests an interrupt.
// RQ17: timer restarts after each time-out with the same rate.
// RQ18: reserved trim bits read zero and ignore writes.
module apt_top (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // device mode pin
  input  wire logic        special_mode,
  // flash trim values
  input  wire logic [5:0]  flash_lp_trim,
  input  wire logic [7:0]  flash_temp_trim,
  // trim and status outputs
  output logic      [5:0]  lowpower_clock_trim_bits,
  output logic      [3:0]  temp_offset_code,
  output logic      [7:0]  factory_test_bits,
  output logic             periodic_timeout_flag,
  output logic             periodic_irq
);
  import apt_pkg::*;

  // register index decode, used by read and write paths
  function automatic logic reg_hit(input logic [7:0] addr, input logic [5:0] idx);
    reg_hit = (addr[1:0] == 2'h0) && (addr[7:2] == idx);
  endfunction

  function automatic logic reg_mapped(input logic [7:0] addr);
    reg_mapped = reg_hit(addr, IDX_CTRL) || reg_hit(addr, IDX_LP_TRIM) ||
                 reg_hit(addr, IDX_RATE_HIGH) || reg_hit(addr, IDX_RATE_LOW) ||
                 reg_hit(addr, IDX_TEST) || reg_hit(addr, IDX_TEMP_TRIM);
  endfunction

  // register state
  logic [5:0]  lp_trim_r;
  logic [7:0]  temp_trim_r;
  logic [15:0] rate_r;
  logic [7:0]  test_r;
  logic        clk_sel_r;
  logic        fe_r;
  logic        ie_r;
  logic        flag_r;
  logic        load_done_r;

  // bus side
  logic        wr_en;
  logic        setup;
  logic [31:0] prdata_r;
  logic        pslverr_r;
  logic [7:0]  rd_byte;

  // mode pin synchroniser
  logic        special_s1_r;
  logic        special_q_r;

  // timer side
  logic        lp_tick;
  logic        timeout;
  logic [3:0]  temp_code_r;
  logic        irq_r;

  // ---------------- apb handshake
  // zero wait states: read data is captured in setup so it is ready at access
  assign pready  = 1'b1;
  assign setup   = psel & ~penable;
  assign wr_en   = psel & penable & pwrite & pstrb[0] & reg_mapped(paddr);
  assign prdata  = prdata_r;
  assign pslverr = pslverr_r;

  always_comb begin
    rd_byte = 8'h00;
    if (reg_hit(paddr, IDX_CTRL)) begin
      rd_byte = {clk_sel_r, 4'h0, fe_r, ie_r, flag_r};
    end else if (reg_hit(paddr, IDX_LP_TRIM)) begin
      rd_byte = {2'h0, lp_trim_r};  // see RQ18
    end else if (reg_hit(paddr, IDX_RATE_HIGH)) begin
      rd_byte = rate_r[15:8];  // see RQ6
    end else if (reg_hit(paddr, IDX_RATE_LOW)) begin
      rd_byte = rate_r[7:0];
    end else if (reg_hit(paddr, IDX_TEST)) begin
      rd_byte = test_r;  // see RQ10
    end else if (reg_hit(paddr, IDX_TEMP_TRIM)) begin
      rd_byte = temp_trim_r & TEMP_MASK;  // see RQ18
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r  <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end else if (setup) begin
      prdata_r  <= {24'h00_0000, rd_byte};
      pslverr_r <= ~reg_mapped(paddr);
    end
  end

  // ---------------- special mode pin, two flops before use
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      special_s1_r <= 1'b0;
      special_q_r  <= 1'b0;
    end else begin
      special_s1_r <= special_mode;
      special_q_r  <= special_s1_r;
    end
  end

  // ---------------- flash load marker
  // reset only forces constants; the flash value is caught on the first edge after release
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      load_done_r <= 1'b0;
    end else begin
      load_done_r <= 1'b1;
    end
  end

  // ---------------- low-power clock trim
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lp_trim_r <= LP_TRIM_RST;
    end else if (!load_done_r) begin
      lp_trim_r <= flash_lp_trim;  // see RQ2
    end else if (wr_en && reg_hit(paddr, IDX_LP_TRIM)) begin
      lp_trim_r <= pwdata[5:0] & LP_TRIM_MASK[5:0];  // see RQ4
    end
  end

  // ---------------- temperature trim
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      temp_trim_r <= TEMP_TRIM_RST;
    end else if (!load_done_r) begin
      temp_trim_r <= flash_temp_trim & TEMP_MASK;  // see RQ11
    end else if (wr_en && reg_hit(paddr, IDX_TEMP_TRIM)) begin
      temp_trim_r <= pwdata[7:0] & TEMP_MASK;  // see RQ4
    end
  end

  // ---------------- periodic rate, locked while the feature runs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rate_r <= RATE_RST;
    end else if (wr_en && !fe_r) begin
      if (reg_hit(paddr, IDX_RATE_HIGH)) begin
        rate_r[15:8] <= pwdata[7:0];  // see RQ5, RQ6
      end
      if (reg_hit(paddr, IDX_RATE_LOW)) begin
        rate_r[7:0] <= pwdata[7:0];  // see RQ5, RQ6
      end
    end
  end

  // ---------------- factory test register
  // the mode pin is a slow strap, so two cycles of sync lag are harmless
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      test_r <= TEST_RST;
    end else if (wr_en && reg_hit(paddr, IDX_TEST) && special_q_r) begin
      test_r <= pwdata[7:0];  // see RQ10
    end
  end

  // ---------------- control: source select
  // a write that also sets the enable cannot move the source
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_sel_r <= 1'b0;
    end else if (wr_en && reg_hit(paddr, IDX_CTRL) && !fe_r && !pwdata[CTRL_FE]) begin
      clk_sel_r <= pwdata[CTRL_CLK_SEL];  // see RQ14
    end
  end

  // ---------------- control: enables
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fe_r <= 1'b0;
      ie_r <= 1'b0;
    end else if (wr_en && reg_hit(paddr, IDX_CTRL)) begin
      fe_r <= pwdata[CTRL_FE];  // see RQ15
      ie_r <= pwdata[CTRL_IE];
    end
  end

  // ---------------- control: time-out flag, set beats clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_r <= 1'b0;
    end else if (timeout) begin
      flag_r <= 1'b1;  // see RQ16
    end else if (wr_en && reg_hit(paddr, IDX_CTRL) && pwdata[CTRL_FLAG]) begin
      flag_r <= 1'b0;  // see RQ16
    end
  end

  // ---------------- outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= (flag_r | timeout) & ie_r;  // see RQ16
    end
  end

  // offset bits pass only while the offset is enabled
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_temp_code
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          temp_code_r[gi] <= 1'b0;
        end else begin
          temp_code_r[gi] <= temp_trim_r[gi] & temp_trim_r[TEMP_OE_BIT];  // see RQ12, RQ13
        end
      end
    end
  endgenerate

  assign lowpower_clock_trim_bits = lp_trim_r;
  assign temp_offset_code         = temp_code_r;
  assign factory_test_bits        = test_r;
  assign periodic_timeout_flag    = flag_r;
  assign periodic_irq             = irq_r;

  // ---------------- submodules
  apt_lp_tick u_lp_tick (
    .pclk    (pclk),
    .presetn (presetn),
    .trim    (lp_trim_r),
    .lp_tick (lp_tick)
  );

  apt_rate_timer u_rate_timer (
    .pclk    (pclk),
    .presetn (presetn),
    .enable  (fe_r),
    .clk_sel (clk_sel_r),
    .rate    (rate_r),
    .lp_tick (lp_tick),
    .timeout (timeout)
  );

  // ---------------- checks
  a_rate_locked: assert property (@(posedge pclk) disable iff (!presetn)  // see RQ6
    (wr_en && fe_r && (reg_hit(paddr, IDX_RATE_HIGH) || reg_hit(paddr, IDX_RATE_LOW)))
      |=> $stable(rate_r))
    else $error("rate changed while feature enabled");

  a_rate_write: assert property (@(posedge pclk) disable iff (!presetn)  // see RQ5
    (wr_en && !fe_r && reg_hit(paddr, IDX_RATE_LOW)) |=> rate_r[7:0] == $past(pwdata[7:0]))
    else $error("rate low byte write lost");

  a_clksel_lock: assert property (@(posedge pclk) disable iff (!presetn)  // see RQ14
    fe_r |=> $stable(clk_sel_r))
    else $error("clock select moved while enabled");

  a_flag_sets: assert property (@(posedge pclk) disable iff (!presetn)  // see RQ16
    timeout |=> flag_r [*2] or (flag_r ##1 !flag_r))
    else $error("time-out did not set flag");

  a_flag_sticky: assert property (@(posedge pclk) disable iff (!presetn)  // see RQ16
    (flag_r && !(wr_en && reg_hit(paddr, IDX_CTRL) && pwdata[CTRL_FLAG])) |=> flag_r)
    else $error("flag cleared without write of one");

  a_irq_follows: assert property (@(posedge pclk) disable iff (!presetn)  // see RQ16
    (timeout && ie_r) |=> periodic_irq)
    else $error("interrupt not raised on time-out");

  a_test_guard: assert property (@(posedge pclk) disable iff (!presetn)  // see RQ10
    (wr_en && reg_hit(paddr, IDX_TEST) && !special_q_r) |=> $stable(test_r))
    else $error("test register written outside special mode");

  a_trim_load: assert property (@(posedge pclk) disable iff (!presetn)  // see RQ2
    !load_done_r |=> lp_trim_r == $past(flash_lp_trim))
    else $error("low-power trim not loaded from flash");

  a_temp_load: assert property (@(posedge pclk) disable iff (!presetn)  // see RQ11
    !load_done_r |=> temp_trim_r == ($past(flash_temp_trim) & TEMP_MASK))
    else $error("temperature trim not loaded from flash");

  a_temp_gate: assert property (@(posedge pclk) disable iff (!presetn)  // see RQ12
    !temp_trim_r[TEMP_OE_BIT] |=> temp_offset_code == 4'h0)
    else $error("offset driven while offset disabled");

  a_temp_pass: assert property (@(posedge pclk) disable iff (!presetn)  // see RQ13
    temp_trim_r[TEMP_OE_BIT] |=> temp_offset_code == $past(temp_trim_r[3:0]))
    else $error("offset bits not passed while enabled");

  a_reserved_zero: assert property (@(posedge pclk) disable iff (!presetn)  // see RQ18
    (setup && reg_hit(paddr, IDX_TEMP_TRIM)) |=> prdata[6:4] == 3'h0 && prdata[31:8] == 24'h00_0000)
    else $error("reserved temperature trim bits read nonzero");

  a_stop_timer: assert property (@(posedge pclk) disable iff (!presetn)  // see RQ15
    !fe_r [*2] |-> !timeout)
    else $error("time-out while feature disabled");

endmodule // apt_top
